// >>> rtl/uafs_baud_gen.sv
// Source clock prescaler and divisor counter of the serial port.
`timescale 1ns/1ps
`default_nettype none
module uafs_baud_gen
  import uafs_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Control.
  input  wire logic       run_in,
  input  wire logic [2:0] source_sel_in,
  input  wire logic [7:0] divisor_in,
  input  wire logic       ext_clk_in,
  // Half-bit tick.
  output logic            half_tick_out
);

  typedef struct packed {
    logic [6:0] pre;
    logic       ext_d;
    logic [7:0] kcnt;
    logic       tick;
  } uafs_bg_st_t;

  uafs_bg_st_t s_r;
  uafs_bg_st_t s_nxt;

  // ****************************************************************
  // Divider.
  // ****************************************************************
  // Prescaler taps the main clock by 2^n; code 0 takes the external
  // clock edge. Prohibited divisors below 8 are run as 8 so the port
  // never locks up on a bad value.
  always_comb begin
    logic [6:0] mask;
    logic       src_tick;
    logic [7:0] k;
    mask     = 7'((8'h01 << source_sel_in) - 8'h01);
    s_nxt    = s_r;
    k        = (divisor_in < DIVISOR_MIN) ? DIVISOR_MIN : divisor_in;
    src_tick = (source_sel_in == 3'h0) ? (ext_clk_in & ~s_r.ext_d)
                                       : ((s_r.pre | ~mask) == 7'h7f);
    s_nxt.ext_d = ext_clk_in;
    s_nxt.pre   = s_r.pre + 7'h01;
    s_nxt.tick  = 1'b0;
    if (src_tick) begin
      if (s_r.kcnt >= k - 8'h01) begin // [RULE18] [RULE19] [RULE23]
        s_nxt.kcnt = 8'h00;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.kcnt = s_r.kcnt + 8'h01;
      end
    end
    if (!run_in) begin
      s_nxt.pre  = 7'h00;
      s_nxt.kcnt = 8'h00;
      s_nxt.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign half_tick_out = s_r.tick;

endmodule
`default_nettype wire

// >>> rtl/uafs_pkg.sv
// Constants, field layouts and shared helpers of the serial port block.
package uafs_pkg;

  // ****************************************************************
  // Register map: word index; byte address is four times the index.
  // ****************************************************************
  localparam int unsigned ADDR_W        = 18;
  localparam logic [15:0] IDX_MODE      = 16'hff90;
  localparam logic [15:0] IDX_DIVISOR   = 16'hff93;
  localparam logic [15:0] IDX_RX_STATUS = 16'hff94;
  localparam logic [15:0] IDX_TX_STATUS = 16'hff95;
  localparam logic [15:0] IDX_AUX       = 16'hff96;
  localparam logic [15:0] IDX_TX_BUF    = 16'hff97;
  localparam logic [15:0] IDX_RX_BUF    = 16'hff98;

  // ****************************************************************
  // Reset values and field positions.
  // ****************************************************************
  localparam logic [7:0] MODE_RST    = 8'h00;
  localparam logic [7:0] DIVISOR_RST = 8'h00;
  localparam logic [7:0] AUX_RST     = 8'h00;
  localparam logic [7:0] BUF_RST     = 8'hff;
  localparam int unsigned RXS_ID     = 3;
  localparam int unsigned RXS_PE     = 2;
  localparam int unsigned RXS_FE     = 1;
  localparam int unsigned RXS_OV     = 0;
  localparam logic [7:0] DIVISOR_MIN = 8'h08;

  // Parity field encodings.
  localparam logic [1:0] PAR_NONE = 2'b00;
  localparam logic [1:0] PAR_ZERO = 2'b01;
  localparam logic [1:0] PAR_ODD  = 2'b10;
  localparam logic [1:0] PAR_EVEN = 2'b11;

  // ****************************************************************
  // Register layouts and states.
  // ****************************************************************
  typedef struct packed {
    logic       port_power_bit;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
    logic [1:0] parity_sel;
    logic       char_length_bit;
    logic       stop_count_bit;
    logic       error_irq_select;
  } uafs_mode_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic       mp_tx_bit;
    logic       mp_mode;
    logic [2:0] source_sel;
  } uafs_aux_t;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_BITS  = 2'b10
  } uafs_rx_st_t;

  typedef enum logic {
    TX_IDLE  = 1'b0,
    TX_SHIFT = 1'b1
  } uafs_tx_st_t;

  // Parity bit for a character; zero parity sends a constant 0.
  function automatic logic uafs_par_bit(input logic [7:0] d,
                                        input logic       char8,
                                        input logic [1:0] sel);
    logic x;
    x = ^{d[7] & char8, d[6:0]};
    case (sel)
      PAR_ODD:  uafs_par_bit = ~x;
      PAR_EVEN: uafs_par_bit = x;
      default:  uafs_par_bit = 1'b0;
    endcase
  endfunction

endpackage

// >>> rtl/uafs_serial_port.sv
// Asynchronous serial port: mode, status, divisor registers on APB.
//
// Contract
// RULE1: character length 7 or 8 bits
// RULE2: transmit one or two stop bits
// RULE3: receiver checks only first stop bit
// RULE4: error irq select chooses complete/error interrupt
// RULE5: zero parity never checked on receive
// RULE6: disable both before parity/length change
// RULE7: disable direction before stop/irq-select change
// RULE8: receive status read-only, resets zero
// RULE9: id flag from appended bit, multiprocessor only
// RULE10: parity error on parity mismatch
// RULE11: framing error when stop bit missing
// RULE12: overrun discards data, repeats until read
// RULE13: power off clears receive status flags
// RULE14: buffer-full set on write, clears on move
// RULE15: shifter-busy set on move, clears when done
// RULE16: software checks buffer-full before second write
// RULE17: software waits idle shifter before disabling
// RULE18: baud output is source divided by k
// RULE19: bit rate main over 2^(n+1)k
// RULE20: divisor written only with both disabled
// RULE21: parity field none, zero, odd, even
// RULE22: power off resets state, line low
// RULE23: source select external or main/2^n
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module uafs_serial_port
  import uafs_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys_in,
  input  wire logic              rst_in,
  // APB slave.
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic [31:0]       pwdata_in,
  output logic      [31:0]       prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Serial line.
  input  wire logic              rxd_in,
  input  wire logic              ext_clk_in,
  output logic                   txd_out,
  // Event pulses.
  output logic                   receive_complete_irq_out,
  output logic                   receive_error_irq_out,
  output logic                   transmit_complete_irq_out
);

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef struct packed {
    uafs_mode_t  mode;
    logic [7:0]  divisor;
    uafs_aux_t   aux;
    logic [7:0]  transmit_buffer;
    logic [7:0]  receive_buffer;
    logic        rx_full;
    logic [3:0]  rx_stat;
    logic        buffer_full_flag;
    logic        shifter_busy_flag;
    uafs_tx_st_t tx_st;
    logic [12:0] transmit_shifter;
    logic [3:0]  tx_cnt;
    logic        tx_half;
    logic        txd;
    uafs_rx_st_t rx_st;
    logic        rx_half;
    logic [3:0]  rx_cnt;
    logic [10:0] rx_sh;
    logic        irq_rc;
    logic        irq_re;
    logic        irq_tc;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } uafs_st_t;

  localparam uafs_st_t ST_RST = '{
    mode:              uafs_mode_t'(MODE_RST),
    divisor:           DIVISOR_RST,
    aux:               uafs_aux_t'(AUX_RST),
    transmit_buffer:   BUF_RST,
    receive_buffer:    BUF_RST,
    tx_st:             TX_IDLE,
    rx_st:             RX_IDLE,
    default:           '0
  };

  uafs_st_t s_r;
  uafs_st_t s_nxt;
  logic     half_tick;

  // ****************************************************************
  // Frame helpers.
  // ****************************************************************
  // Builds the outgoing frame LSB first, idle ones above the last bit.
  // Returns the bit count in the top nibble.
  function automatic logic [16:0] build_frame(input logic [7:0] d,
                                              input uafs_mode_t m,
                                              input uafs_aux_t  a);
    logic [12:0] f;
    logic [3:0]  p;
    f    = 13'h1fff;
    f[0] = 1'b0;
    p    = 4'd8;
    for (int i = 0; i < 7; i++) begin
      f[i+1] = d[i];
    end
    if (m.char_length_bit) begin // [RULE1]
      f[p] = d[7];
      p    = p + 4'd1;
    end
    if (m.parity_sel != PAR_NONE) begin // [RULE21]
      f[p] = uafs_par_bit(d, m.char_length_bit, m.parity_sel);
      p    = p + 4'd1;
    end
    if (a.mp_mode) begin
      f[p] = a.mp_tx_bit;
      p    = p + 4'd1;
    end
    p = p + (m.stop_count_bit ? 4'd2 : 4'd1); // [RULE2]
    return {p, f};
  endfunction

  // Received bits after the start bit; always a single stop bit.
  function automatic logic [3:0] rx_len(input uafs_mode_t m,
                                        input uafs_aux_t  a);
    rx_len = (m.char_length_bit ? 4'd8 : 4'd7)
           + {3'h0, m.parity_sel != PAR_NONE}
           + {3'h0, a.mp_mode}
           + 4'd1; // [RULE3]
  endfunction

  // ****************************************************************
  // Baud generator.
  // ****************************************************************
  uafs_baud_gen u_baud (
    .clk_sys_in    (clk_sys_in),
    .rst_in        (rst_in),
    .run_in        (s_r.mode.port_power_bit &
                    (s_r.mode.transmit_enable_bit |
                     s_r.mode.receive_enable_bit)),
    .source_sel_in (s_r.aux.source_sel),
    .divisor_in    (s_r.divisor),
    .ext_clk_in    (ext_clk_in),
    .half_tick_out (half_tick)
  );

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  // Bus side first, line events after, so a hardware set wins.
  always_comb begin
    logic        setup;
    logic        access;
    logic [15:0] idx;
    logic [7:0]  rd;
    logic        hit;
    logic [16:0] fr;
    logic [7:0]  data;
    logic [3:0]  pos;
    logic        pe;
    logic        fe;
    logic        ov;
    s_nxt  = s_r;
    setup  = psel_in & ~penable_in;
    access = psel_in & penable_in & s_r.pready;
    idx    = paddr_in[ADDR_W-1:2];
    rd     = 8'h00;
    hit    = 1'b1;
    fr     = 17'h0;
    data   = 8'h00;
    pos    = 4'h0;
    pe     = 1'b0;
    fe     = 1'b0;
    ov     = 1'b0;
    s_nxt.irq_rc = 1'b0;
    s_nxt.irq_re = 1'b0;
    s_nxt.irq_tc = 1'b0;

    // Read mux; the answer is latched in the setup cycle.
    case (idx)
      IDX_MODE:      rd = s_r.mode;
      IDX_DIVISOR:   rd = s_r.divisor;
      IDX_RX_STATUS: rd = {4'h0, s_r.rx_stat}; // [RULE8]
      IDX_TX_STATUS: rd = {6'h00, s_r.buffer_full_flag,
                           s_r.shifter_busy_flag};
      IDX_AUX:       rd = s_r.aux;
      IDX_TX_BUF:    rd = s_r.transmit_buffer;
      IDX_RX_BUF:    rd = s_r.receive_buffer;
      default:       hit = 1'b0;
    endcase
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.prdata  = {24'h000000, rd};
      s_nxt.pslverr = ~hit;
    end

    // Writes and read side effects take place at the access edge.
    if (access && !s_r.pslverr) begin
      if (pwrite_in) begin
        case (idx)
          IDX_MODE:    s_nxt.mode    = uafs_mode_t'(pwdata_in[7:0]);
          IDX_DIVISOR: s_nxt.divisor = pwdata_in[7:0];
          IDX_AUX:     s_nxt.aux     = uafs_aux_t'({3'h0,
                                                    pwdata_in[4:0]});
          IDX_TX_BUF: begin
            // A write while the buffer holds data is dropped.
            if (!s_r.buffer_full_flag &&
                s_r.mode.port_power_bit &&
                s_r.mode.transmit_enable_bit) begin
              s_nxt.transmit_buffer  = pwdata_in[7:0];
              s_nxt.buffer_full_flag = 1'b1; // [RULE14]
            end
          end
          default: ;
        endcase
      end else if (idx == IDX_RX_BUF) begin
        s_nxt.rx_full = 1'b0;
      end
    end

    // Transmitter.
    case (s_r.tx_st)
      TX_IDLE: ;
      TX_SHIFT: begin
        if (half_tick) begin
          s_nxt.tx_half = ~s_r.tx_half;
          if (s_r.tx_half) begin
            s_nxt.transmit_shifter = {1'b1,
                                      s_r.transmit_shifter[12:1]};
            s_nxt.tx_cnt = s_r.tx_cnt - 4'd1;
            if (s_r.tx_cnt == 4'd1) begin
              s_nxt.tx_st  = TX_IDLE;
              s_nxt.irq_tc = 1'b1;
              // A pending byte keeps the shifter marked busy.
              if (!s_nxt.buffer_full_flag) begin
                s_nxt.shifter_busy_flag = 1'b0; // [RULE15]
              end
            end
          end
        end
      end
      default: s_nxt.tx_st = TX_IDLE;
    endcase

    // Load on a half tick: full start bit, no gap after a stop bit.
    if (s_nxt.tx_st == TX_IDLE && s_r.buffer_full_flag && half_tick) begin
      fr = build_frame(s_r.transmit_buffer, s_r.mode, s_r.aux);
      s_nxt.transmit_shifter  = fr[12:0];
      s_nxt.tx_cnt            = fr[16:13];
      s_nxt.tx_half           = 1'b0;
      s_nxt.buffer_full_flag  = 1'b0; // [RULE14]
      s_nxt.shifter_busy_flag = 1'b1; // [RULE15]
      s_nxt.tx_st             = TX_SHIFT;
    end

    // Receiver: start is confirmed at the next half tick of the free-running
    // divider, then one sample per bit time.
    case (s_r.rx_st)
      RX_IDLE: begin
        if (!rxd_in) begin
          s_nxt.rx_st = RX_START;
        end
      end
      RX_START: begin
        if (half_tick) begin
          s_nxt.rx_st   = rxd_in ? RX_IDLE : RX_BITS;
          s_nxt.rx_cnt  = 4'd0;
          s_nxt.rx_half = 1'b0;
        end
      end
      RX_BITS: begin
        if (half_tick) begin
          s_nxt.rx_half = ~s_r.rx_half;
          if (s_r.rx_half) begin
            s_nxt.rx_sh[s_r.rx_cnt] = rxd_in;
            s_nxt.rx_cnt = s_r.rx_cnt + 4'd1;
            if (s_nxt.rx_cnt == rx_len(s_r.mode, s_r.aux)) begin
              s_nxt.rx_st = RX_IDLE;
              data = s_r.mode.char_length_bit ? s_nxt.rx_sh[7:0]
                     : {1'b0, s_nxt.rx_sh[6:0]}; // [RULE1]
              pos  = s_r.mode.char_length_bit ? 4'd8 : 4'd7;
              if (s_r.mode.parity_sel != PAR_NONE) begin
                // Zero parity is skipped but never checked.
                pe  = s_r.mode.parity_sel[1] && // [RULE5] [RULE10]
                      (s_nxt.rx_sh[pos] !=
                       uafs_par_bit(data, s_r.mode.char_length_bit,
                                    s_r.mode.parity_sel));
                pos = pos + 4'd1;
              end
              if (s_r.aux.mp_mode) begin
                if (s_nxt.rx_sh[pos]) begin
                  s_nxt.rx_stat[RXS_ID] = 1'b1; // [RULE9]
                end
                pos = pos + 4'd1;
              end
              fe = ~s_nxt.rx_sh[pos]; // [RULE3] [RULE11]
              ov = s_r.rx_full;
              if (ov) begin
                s_nxt.rx_stat[RXS_OV] = 1'b1; // [RULE12]
              end else begin
                s_nxt.receive_buffer = data;
                s_nxt.rx_full        = 1'b1;
              end
              if (pe) begin
                s_nxt.rx_stat[RXS_PE] = 1'b1;
              end
              if (fe) begin
                s_nxt.rx_stat[RXS_FE] = 1'b1;
              end
              if ((pe | fe | ov) && s_r.mode.error_irq_select) begin
                s_nxt.irq_re = 1'b1; // [RULE4]
              end else begin
                s_nxt.irq_rc = 1'b1; // [RULE4]
              end
            end
          end
        end
      end
      default: s_nxt.rx_st = RX_IDLE;
    endcase

    // Disabled directions are held in reset.
    if (!s_r.mode.transmit_enable_bit) begin
      s_nxt.tx_st             = TX_IDLE;
      s_nxt.buffer_full_flag  = 1'b0; // [RULE14]
      s_nxt.shifter_busy_flag = 1'b0; // [RULE15]
      s_nxt.irq_tc            = 1'b0;
    end
    if (!s_r.mode.receive_enable_bit) begin
      s_nxt.rx_st  = RX_IDLE;
      s_nxt.irq_rc = 1'b0;
      s_nxt.irq_re = 1'b0;
    end

    // Power off clears the port's state but keeps mode, divisor, aux and transmit buffer;
    // done with the system clock so no flop sees an asynchronous clear from a register bit.
    if (!s_r.mode.port_power_bit) begin
      s_nxt.tx_st             = TX_IDLE;
      s_nxt.rx_st             = RX_IDLE;
      s_nxt.buffer_full_flag  = 1'b0;
      s_nxt.shifter_busy_flag = 1'b0;
      s_nxt.rx_stat           = 4'h0; // [RULE13]
      s_nxt.rx_full           = 1'b0; // [RULE22]
      s_nxt.receive_buffer    = BUF_RST;
      s_nxt.irq_rc            = 1'b0;
      s_nxt.irq_re            = 1'b0;
      s_nxt.irq_tc            = 1'b0;
    end

    // Line level: low when unpowered, mark when idle.
    if (!s_nxt.mode.port_power_bit) begin
      s_nxt.txd = 1'b0; // [RULE22]
    end else if (s_nxt.tx_st == TX_SHIFT) begin
      s_nxt.txd = s_nxt.transmit_shifter[0];
    end else begin
      s_nxt.txd = 1'b1;
    end
  end

  // ****************************************************************
  // State register.
  // ****************************************************************
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register.
  assign prdata_out                = s_r.prdata;
  assign pready_out                = s_r.pready;
  assign pslverr_out               = s_r.pslverr;
  assign txd_out                   = s_r.txd;
  assign receive_complete_irq_out  = s_r.irq_rc;
  assign receive_error_irq_out     = s_r.irq_re;
  assign transmit_complete_irq_out = s_r.irq_tc;

endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the serial port: registers, transmit, receive.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top
  import uafs_pkg::*;
;
  logic              clk_sys_in, rst_in, psel, penable, pwrite;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, rdat;
  logic              pready, pslverr, rxd, txd, rc, re, tc, rerr;
  logic [4:0]        frame_len;
  int                failures, num_checks, cyc, n_rc, n_re;

  uafs_serial_port i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .rxd_in(rxd),
    .ext_clk_in(1'b0), .txd_out(txd), .receive_complete_irq_out(rc),
    .receive_error_irq_out(re), .transmit_complete_irq_out(tc));
  // Divisor 8 on main/2 gives a bit time of 32 clocks.
  uafs_line_partner i_line (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .txd_in(txd), .frame_len_in(frame_len), .bit_cyc_in(8'h20),
    .rxd_out(rxd));

  // Clock.
  initial begin
    clk_sys_in = 1'b0;
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  // Event counts and a hang limit well above the run's length.
  always @(posedge clk_sys_in) begin
    if (rc === 1'b1) n_rc++;
    if (re === 1'b1) n_re++;
    cyc++;
    if (cyc == 30000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // One APB transfer; an idle cycle follows so no signal is set twice.
  task automatic apb(input logic w, input logic [15:0] idx,
                     input logic [7:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] idx,
                        input logic [7:0] x);
    apb(1'b0, idx, 8'h00);
    `CHK(nm, {24'h0, x}, rdat)
  endtask

  // Polls transmit status until the masked flags drop, with a bound.
  task automatic poll_tx(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, IDX_TX_STATUS, 8'h00);
      n++;
    end while ((rdat[7:0] & m) != 8'h00 && n < 200);
  endtask

  function automatic logic [15:0] f8(input logic [7:0] d);
    f8 = {4'h0, 2'b11, ^d, d, 1'b0};
  endfunction
  function automatic logic [15:0] f7(input logic [7:0] d);
    f7 = {6'h0, 1'b1, 1'b0, d[6:0], 1'b0};
  endfunction

  task automatic t_regs();
    rd_chk("divisor", IDX_DIVISOR, 8'h00);
    rd_chk("rx status", IDX_RX_STATUS, 8'h00);
    rd_chk("tx status", IDX_TX_STATUS, 8'h00);
    wr(IDX_RX_STATUS, 8'hff);
    rd_chk("rx status ro", IDX_RX_STATUS, 8'h00);
    apb(1'b0, 16'hff91, 8'h00);
    `CHK("unmapped err", 1'b1, rerr)
  endtask

  // Two back-to-back bytes; the second is written once the buffer frees.
  task automatic t_tx(input logic [7:0] mode, input logic [4:0] len,
                      input logic [7:0] d0, input logic [7:0] d1);
    int n;
    wr(IDX_MODE, 8'h80);
    wr(IDX_DIVISOR, 8'h08);
    wr(IDX_AUX, 8'h01);
    wr(IDX_MODE, mode);
    frame_len <= len;
    while (i_line.mon) @(posedge clk_sys_in);
    i_line.got_q.delete();
    i_line.stamp_q.delete();
    wr(IDX_TX_BUF, d0);
    poll_tx(8'h02);
    `CHK("busy after move", 32'h1, rdat)
    wr(IDX_TX_BUF, d1);
    rd_chk("both full", IDX_TX_STATUS, 8'h03);
    n = 0;
    while (i_line.got_q.size() < 2 && n < 2000) begin
      @(posedge clk_sys_in);
      n++;
    end
    `CHK("frame 0", len == 12 ? f8(d0) : f7(d0), i_line.got_q[0])
    `CHK("frame 1", len == 12 ? f8(d1) : f7(d1), i_line.got_q[1])
    `CHK("spacing", len * 32, i_line.stamp_q[1] - i_line.stamp_q[0])
    poll_tx(8'h03);
    `CHK("idle after", 32'h0, rdat)
  endtask

  // Receive errors with the error event selected, then power off.
  task automatic t_rx_a();
    int c;
    wr(IDX_MODE, 8'h80);
    wr(IDX_MODE, 8'hff);
    c = n_rc;
    i_line.send({1'b1, 1'b0, 8'h3c}, 10);
    rd_chk("rx good", IDX_RX_STATUS, 8'h00);
    `CHK("complete event", c + 1, n_rc)
    rd_chk("rx data", IDX_RX_BUF, 8'h3c);
    i_line.send({1'b1, 1'b0, 8'h5a, 1'b0, 1'b1, 1'b0, 8'h3c}, 21);
    rd_chk("overrun", IDX_RX_STATUS, 8'h01);
    rd_chk("kept data", IDX_RX_BUF, 8'h3c);
    c = n_re;
    i_line.send({1'b1, 1'b1, 8'h3c}, 10);
    rd_chk("parity", IDX_RX_STATUS, 8'h05);
    `CHK("error event", c + 1, n_re)
    rd_chk("flush", IDX_RX_BUF, 8'h3c);
    i_line.send({1'b0, 1'b0, 8'h3c}, 10);
    rd_chk("framing", IDX_RX_STATUS, 8'h07);
    wr(IDX_MODE, 8'h00);
    rd_chk("power off", IDX_RX_STATUS, 8'h00);
    rd_chk("tx off", IDX_TX_STATUS, 8'h00);
  endtask

  // Seven-bit zero parity, error reported through the ordinary event.
  task automatic t_rx_b();
    int c;
    i_line.send({1'b1, 1'b1, 7'h55}, 9);
    rd_chk("zero par", IDX_RX_STATUS, 8'h00);
    rd_chk("seven bit", IDX_RX_BUF, 8'h55);
    c = n_rc;
    i_line.send({1'b0, 1'b0, 7'h2a}, 9);
    `CHK("sel0 event", c + 1, n_rc)
    rd_chk("framing b", IDX_RX_STATUS, 8'h02);
  endtask

  // Main sequence.
  initial begin
    {failures, num_checks, cyc, n_rc, n_re} = '0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    frame_len = 5'd12;
    rst_in    = 1'b1;
    repeat (16) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    t_regs();
    t_tx(8'hfe, 5'd12, 8'ha5, 8'h3c);
    t_rx_a();
    t_tx(8'he8, 5'd10, 8'h4b, 8'h12);
    t_rx_b();
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> tb/uafs_line_partner.sv
// Remote serial transceiver model facing the port's line pins.
`timescale 1ns/1ps
`default_nettype none
module uafs_line_partner (
  // Clock and reset.
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  // Line and frame shape.
  input  wire logic       txd_in,
  input  wire logic [4:0] frame_len_in,
  input  wire logic [7:0] bit_cyc_in,
  output logic            rxd_out
);
  logic [15:0] got_q[$];
  int          stamp_q[$];
  logic [15:0] sh;
  logic        mon = 1'b0;
  logic        last = 1'b0;
  int          cyc = 0;
  int          ph;
  int          k;

  // The line idles high, as a pulled-up receive pin would.
  initial rxd_out = 1'b1;

  // Start bit, then n bits first-bit-first, each one bit time long.
  task automatic send(input logic [31:0] bits, input int n);
    rxd_out <= 1'b0;
    repeat (bit_cyc_in) @(posedge clk_sys_in);
    for (int i = 0; i < n; i++) begin
      rxd_out <= bits[i];
      repeat (bit_cyc_in) @(posedge clk_sys_in);
    end
    rxd_out <= 1'b1;
  endtask

  // Catches frames at mid-bit from a falling edge; stamps keep spacing.
  always @(posedge clk_sys_in) begin
    cyc++;
    if (rst_in) begin
      mon = 1'b0;
    end else if (mon) begin
      ph++;
      if (ph % bit_cyc_in == bit_cyc_in / 2) begin
        sh[k] = txd_in;
        k++;
        if (k == frame_len_in) begin
          mon = 1'b0;
          got_q.push_back(sh);
        end
      end
    end else if (last && !txd_in) begin
      mon = 1'b1;
      ph  = 0;
      k   = 0;
      sh  = 16'h0;
      stamp_q.push_back(cyc);
    end
    last = txd_in;
  end
endmodule
`default_nettype wire

// >>> tb/uafs_port_sva.sv
// Concurrent checks on the serial port's bus, line and event outputs.
`timescale 1ns/1ps
`default_nettype none
module uafs_port_sva
  import uafs_pkg::*;
(
  // Clock and reset.
  input wire logic              clk_sys_in,
  input wire logic              rst_in,
  // APB.
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [31:0]       prdata_out,
  input wire logic              pready_out,
  input wire logic              pslverr_out,
  // Line and events.
  input wire logic              txd_out,
  input wire logic              receive_complete_irq_out,
  input wire logic              receive_error_irq_out,
  input wire logic              transmit_complete_irq_out
);
  logic [15:0] idx;
  logic        mapped;
  logic        pwr_r;

  // ********
  // Helpers
  // ********
  // Word index and decode of the mapped places.
  assign idx    = paddr_in[17:2];
  assign mapped = (idx == IDX_MODE) || (idx >= IDX_DIVISOR && idx <= IDX_RX_BUF);

  // Shadow of the power bit, taken from committed mode writes only.
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pwr_r <= 1'b0;
    end else if (psel_in && penable_in && pready_out && pwrite_in &&
                 idx == IDX_MODE) begin
      pwr_r <= pwdata_in[7];
    end
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // ********
  // Checks
  // ********
  a_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready_out |=> !pready_out)
    else $error("pready held too long");
  a_err_unmapped: assert property (pready_out |-> pslverr_out == !mapped)
    else $error("pslverr does not match decode");
  a_rx_status_high: assert property (pready_out && !pwrite_in &&
      idx == IDX_RX_STATUS |-> prdata_out[31:4] == 28'h0)
    else $error("receive status upper bits set");
  a_tx_status_high: assert property (pready_out && !pwrite_in &&
      idx == IDX_TX_STATUS |-> prdata_out[31:2] == 30'h0)
    else $error("transmit status upper bits set");
  a_irq_exclusive: assert property (!(receive_complete_irq_out &&
      receive_error_irq_out))
    else $error("both receive events at once");
  a_err_irq_pulse: assert property ($rose(receive_error_irq_out) |=>
      !receive_error_irq_out)
    else $error("error event longer than one cycle");
  a_line_low_off: assert property (!pwr_r [*2] |-> !txd_out)
    else $error("line not low while unpowered");
  a_done_powered: assert property (transmit_complete_irq_out |->
      $past(pwr_r))
    else $error("transmit done while unpowered");
endmodule

bind uafs_serial_port uafs_port_sva i_sva (.*);
`default_nettype wire
